/* hw/tcf_framer.sv */
// Operation
// - clear both encoders at block start, then run them for k+4 bit times
// - first k bit times feed information bits into both encoders
// - last 4 bit times feed each encoder its own feedback, ending at zero
// - keep emitting during termination; systematic carries 4 feedback bits
// - each codeblock holds exactly (k+4)/r symbols
// - rate 1/3 order: systematic, first parity one, second parity one
// - rate 1/4 order: systematic, first parity two, three, second parity one
// - rate 1/6 order: systematic, first one two three, second one three
// - rate 1/2: systematic and first parity, then systematic and second parity
// - coded data: marker joins encoder output without being encoded
// - uncoded channel: marker sits directly in front of each frame
// - inner code downstream encodes marker; outer code never sees it
// - non-turbo marker is 32-bit 1ACFFC1D
// - turbo marker length 32/r; rate 1/2 uses 034776C7272895B0
// - rate 1/3 marker is 25D5C0CE8990F6C9461BF79C
// - rate 1/4 marker is rate 1/2 pattern then FCB88938D8D76A4F
// - rate 1/6 marker is rate 1/3 pattern then DA2A3F31766F0936B9E40863
// - marker leaves most significant bit first
// - marker follows previous block's last symbol with no gap
// - feedback taps 10011; first parity taps 11011 on both encoders
// - rate 1/4 first encoder uses 10101 and 11111; second uses 11011
`timescale 1ns/100ps
`default_nettype none
module tcf_framer
    import tcf_pkg::*;
#(
    parameter int KW = 15
) (
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic          run_en,
    input  wire logic          turbo_en,
    input  wire logic [1:0]    rate_sel,
    input  wire logic [KW-1:0] block_len,
    input  wire logic          info_bit,
    input  wire logic          info_bit_perm,
    input  wire logic          info_valid,
    output logic               info_ready,
    output logic               sym_out_q,
    output logic               sym_valid_q,
    output logic               sym_is_marker_q,
    output logic               sym_unit_start_q,
    input  wire logic          sym_ready
);

    // ==========================================================
    // elaboration checks
    if (KW < 3 || KW > 24) begin : g_bad_kw
        $error("tcf_framer: KW out of range");
    end

    // ==========================================================
    // helper functions
    // parity of an adder input and the four register stages under a tap vector
    function automatic logic tap_xor(input logic [4:0] taps, input logic a,
                                     input logic [3:0] d);
        tap_xor = (taps[4] & a) ^ (taps[3] & d[0]) ^ (taps[2] & d[1])
                ^ (taps[1] & d[2]) ^ (taps[0] & d[3]);
    endfunction

    // symbols per bit time for the latched mode
    function automatic logic [2:0] sym_per_bit(input logic turbo, input tcf_rate_t r);
        if (!turbo) begin
            sym_per_bit = SPB_PLAIN;
        end else begin
            unique case (r)
                RATE_HALF:    sym_per_bit = SPB_HALF;
                RATE_THIRD:   sym_per_bit = SPB_THIRD;
                RATE_QUARTER: sym_per_bit = SPB_QUARTER;
                RATE_SIXTH:   sym_per_bit = SPB_SIXTH;
            endcase
        end
    endfunction

    // marker pattern for the latched mode
    function automatic logic [191:0] mark_word(input logic turbo, input tcf_rate_t r);
        if (!turbo) begin
            mark_word = MARK_PLAIN;
        end else begin
            unique case (r)
                RATE_HALF:    mark_word = MARK_HALF;
                RATE_THIRD:   mark_word = MARK_THIRD;
                RATE_QUARTER: mark_word = MARK_QUARTER;
                RATE_SIXTH:   mark_word = MARK_SIXTH;
            endcase
        end
    endfunction

    // ==========================================================
    // state and datapath signals
    tcf_state_t      state_q;
    tcf_rate_t       rate_q;
    logic            turbo_q;
    logic [KW-1:0]   k_q;
    logic [7:0]      mk_idx_q;
    logic [KW:0]     bit_cnt_q;
    logic [2:0]      sym_idx_q;
    logic [3:0]      enc_a_q;
    logic [3:0]      enc_b_q;
    logic            hold_a_q;
    logic            hold_b_q;
    logic [2:0]      spb;
    logic [7:0]      mlen;
    logic [191:0]    mark_pat;
    logic            first_sym;
    logic            need_in;
    logic            out_free;
    logic            adv;
    logic            bit_end;
    logic            mark_end;
    logic            data_end;
    logic            blk_end;
    logic            fb_a;
    logic            fb_b;
    logic            u_a;
    logic            u_b;
    logic            a_a;
    logic            a_b;
    logic            p1a;
    logic            p2a;
    logic            p3a;
    logic            p1b;
    logic            p3b;
    logic            mark_bit;
    logic            sym_d;

    assign spb       = sym_per_bit(turbo_q, rate_q);
    assign mlen      = MLEN_PLAIN * {5'h00, spb};
    assign mark_pat  = mark_word(turbo_q, rate_q);
    assign first_sym = (sym_idx_q == 3'h0);

    // ==========================================================
    // advance control: one symbol per cycle while output slot is free
    assign out_free   = !sym_valid_q || sym_ready;
    assign need_in    = (state_q == ST_DATA) && first_sym;
    assign adv        = (state_q != ST_IDLE) && out_free && (!need_in || info_valid);
    assign info_ready = need_in && out_free;
    assign bit_end    = (sym_idx_q == spb - 3'h1);
    assign mark_end   = (state_q == ST_MARK) && (mk_idx_q == mlen - 8'h01);
    assign data_end   = (state_q == ST_DATA) && bit_end
                      && (bit_cnt_q == {1'b0, k_q} - {{KW{1'b0}}, 1'b1});
    assign blk_end    = adv && bit_end
                      && (((state_q == ST_TAIL)
                           && (bit_cnt_q == {1'b0, k_q} + (KW+1)'(TAIL_BITS - 1)))
                          || (data_end && !turbo_q));

    // ==========================================================
    // encoder inputs: information bits, then own feedback during tail
    assign fb_a = tap_xor(TAPS_FEEDBACK & 5'h0F, 1'b0, enc_a_q);
    assign fb_b = tap_xor(TAPS_FEEDBACK & 5'h0F, 1'b0, enc_b_q);
    always_comb begin
        if (state_q == ST_TAIL) begin
            u_a = fb_a;
            u_b = fb_b;
        end else if (first_sym) begin
            u_a = info_bit;
            u_b = info_bit_perm;
        end else begin
            u_a = hold_a_q;
            u_b = hold_b_q;
        end
    end
    assign a_a = u_a ^ fb_a;
    assign a_b = u_b ^ fb_b;

    // parity outputs
    assign p1a = tap_xor(TAPS_FWD_ONE, a_a, enc_a_q);
    assign p2a = tap_xor(TAPS_FWD_TWO, a_a, enc_a_q);
    assign p3a = tap_xor(TAPS_FWD_THREE, a_a, enc_a_q);
    assign p1b = tap_xor(TAPS_FWD_ONE, a_b, enc_b_q);
    assign p3b = tap_xor(TAPS_FWD_THREE, a_b, enc_b_q);

    // marker bit, most significant first
    assign mark_bit = mark_pat[8'(MARK_FIELD - 1) - mk_idx_q];

    // ==========================================================
    // symbol multiplexer
    always_comb begin
        sym_d = u_a;
        if (state_q == ST_MARK) begin
            sym_d = mark_bit;
        end else if (turbo_q && !first_sym) begin
            unique case (rate_q)
                RATE_HALF:    sym_d = bit_cnt_q[0] ? p1b : p1a;
                RATE_THIRD:   sym_d = (sym_idx_q == 3'h1) ? p1a : p1b;
                RATE_QUARTER: begin
                    unique case (sym_idx_q)
                        3'h1:    sym_d = p2a;
                        3'h2:    sym_d = p3a;
                        default: sym_d = p1b;
                    endcase
                end
                RATE_SIXTH: begin
                    unique case (sym_idx_q)
                        3'h1:    sym_d = p1a;
                        3'h2:    sym_d = p2a;
                        3'h3:    sym_d = p3a;
                        3'h4:    sym_d = p1b;
                        default: sym_d = p3b;
                    endcase
                end
            endcase
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: if (run_en) state_q <= ST_MARK;
                ST_MARK: if (adv && mark_end) state_q <= ST_DATA;
                ST_DATA: begin
                    if (blk_end) begin
                        state_q <= run_en ? ST_MARK : ST_IDLE;
                    end else if (adv && data_end) begin
                        state_q <= ST_TAIL;
                    end
                end
                ST_TAIL: if (blk_end) state_q <= run_en ? ST_MARK : ST_IDLE;
            endcase
        end
    end

    // mode latch at marker start
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rate_q  <= RATE_HALF;
            turbo_q <= 1'b0;
            k_q     <= KW'(BLOCK_LEN_DEF);
        end else if (run_en && (state_q == ST_IDLE || blk_end)) begin
            rate_q  <= tcf_rate_t'(rate_sel);
            turbo_q <= turbo_en;
            k_q     <= block_len;
        end
    end

    // marker, bit and symbol counters
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mk_idx_q  <= 8'h00;
            bit_cnt_q <= '0;
            sym_idx_q <= 3'h0;
        end else if (adv) begin
            if (state_q == ST_MARK) begin
                mk_idx_q  <= mark_end ? 8'h00 : mk_idx_q + 8'h01;
                bit_cnt_q <= '0;
            end else begin
                sym_idx_q <= bit_end ? 3'h0 : sym_idx_q + 3'h1;
                if (bit_end) bit_cnt_q <= blk_end ? '0 : bit_cnt_q + (KW+1)'(1);
            end
        end
    end

    // component encoders: cleared in idle and the marker, shifted once per bit time in turbo mode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            enc_a_q <= 4'h0;
            enc_b_q <= 4'h0;
        end else if (state_q == ST_MARK || state_q == ST_IDLE) begin
            enc_a_q <= 4'h0;
            enc_b_q <= 4'h0;
        end else if (adv && bit_end && turbo_q) begin
            enc_a_q <= {enc_a_q[2:0], a_a};
            enc_b_q <= {enc_b_q[2:0], a_b};
        end
    end

    // information bits held for the rest of the bit time
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hold_a_q <= 1'b0;
            hold_b_q <= 1'b0;
        end else if (adv && need_in) begin
            hold_a_q <= info_bit;
            hold_b_q <= info_bit_perm;
        end
    end

    // registered symbol output
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sym_out_q        <= 1'b0;
            sym_valid_q      <= 1'b0;
            sym_is_marker_q  <= 1'b0;
            sym_unit_start_q <= 1'b0;
        end else if (adv) begin
            sym_out_q        <= sym_d;
            sym_valid_q      <= 1'b1;
            sym_is_marker_q  <= (state_q == ST_MARK);
            sym_unit_start_q <= (state_q == ST_MARK) && (mk_idx_q == 8'h00);
        end else if (sym_ready) begin
            sym_valid_q      <= 1'b0;
            sym_unit_start_q <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    logic [KW+3:0] blk_sym_q; // symbols of the current codeblock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            blk_sym_q <= '0;
        end else if (state_q == ST_MARK) begin
            blk_sym_q <= '0;
        end else if (adv) begin
            blk_sym_q <= blk_sym_q + (KW+4)'(1);
        end
    end
    sequence s_last_tail;
        blk_end && turbo_q;
    endsequence
    sequence s_mark_bit;
        adv && (state_q == ST_MARK);
    endsequence
    property p_enc_clear;
        @(posedge clock) disable iff (!rstn)
        (state_q == ST_MARK) ##1 (state_q == ST_DATA) |-> (enc_a_q == 4'h0) && (enc_b_q == 4'h0);
    endproperty
    a_enc_clear: assert property (p_enc_clear) else $error("encoders not clear");
    property p_term;
        @(posedge clock) disable iff (!rstn)
        s_last_tail |=> (enc_a_q == 4'h0) && (enc_b_q == 4'h0);
    endproperty
    a_term: assert property (p_term) else $error("trellis not terminated");
    property p_len;
        @(posedge clock) disable iff (!rstn)
        blk_end |-> (blk_sym_q + (KW+4)'(1)) == (KW+4)'(({4'h0, k_q}
            + (KW+4)'(turbo_q ? TAIL_BITS : 0)) * spb);
    endproperty
    a_len: assert property (p_len) else $error("wrong codeblock length");
    property p_stall;
        @(posedge clock) disable iff (!rstn)
        (state_q == ST_MARK || state_q == ST_TAIL) |-> !info_ready;
    endproperty
    a_stall: assert property (p_stall) else $error("input taken outside data");
    property p_b2b;
        @(posedge clock) disable iff (!rstn)
        blk_end && run_en |=> (state_q == ST_MARK) && (mk_idx_q == 8'h00);
    endproperty
    a_b2b: assert property (p_b2b) else $error("gap before marker");
    property p_mark;
        @(posedge clock) disable iff (!rstn)
        s_mark_bit |=> sym_out_q == mark_pat[8'd191 - $past(mk_idx_q)];
    endproperty
    a_mark: assert property (p_mark) else $error("marker bit wrong");
    property p_hold;
        @(posedge clock) disable iff (!rstn)
        (state_q == ST_DATA || state_q == ST_TAIL) && !blk_end
        |=> $stable(rate_q) && $stable(k_q) && $stable(turbo_q);
    endproperty
    a_hold: assert property (p_hold) else $error("mode changed in block");
    property p_sys;
        @(posedge clock) disable iff (!rstn)
        adv && need_in |=> sym_out_q == $past(info_bit) && !sym_is_marker_q;
    endproperty
    a_sys: assert property (p_sys) else $error("systematic bit wrong");
endmodule
`default_nettype wire

/* hw/tcf_pkg.sv */
`default_nettype none
// ==========================================================
// shared constants for the codeblock sync framer
package tcf_pkg;

    // nominal code rate selections, in rate_sel order 0..3
    typedef enum logic [1:0] {RATE_HALF, RATE_THIRD, RATE_QUARTER, RATE_SIXTH} tcf_rate_t;

    // framer sequencing states
    typedef enum logic [1:0] {ST_IDLE, ST_MARK, ST_DATA, ST_TAIL} tcf_state_t;

    // ==========================================================
    // encoder tap vectors, leftmost bit is the adder input
    localparam logic [4:0] TAPS_FEEDBACK   = 5'h13; // 10011
    localparam logic [4:0] TAPS_FWD_ONE    = 5'h1B; // 11011
    localparam logic [4:0] TAPS_FWD_TWO    = 5'h15; // 10101
    localparam logic [4:0] TAPS_FWD_THREE  = 5'h1F; // 11111
    localparam int         ENC_STAGES      = 4;
    localparam int         TAIL_BITS       = 4;

    // ==========================================================
    // sync markers, left aligned in a 192-bit field, first sent bit on the left
    localparam int           MARK_FIELD    = 192;
    localparam logic [191:0] MARK_PLAIN    = {32'h1ACFFC1D, 160'h0};
    localparam logic [191:0] MARK_HALF     = {64'h034776C7272895B0, 128'h0};
    localparam logic [191:0] MARK_THIRD    = {96'h25D5C0CE8990F6C9461BF79C, 96'h0};
    localparam logic [191:0] MARK_QUARTER  = {64'h034776C7272895B0,
                                              64'hFCB88938D8D76A4F, 64'h0};
    localparam logic [191:0] MARK_SIXTH    = {96'h25D5C0CE8990F6C9461BF79C,
                                              96'hDA2A3F31766F0936B9E40863};
    localparam logic [7:0]   MLEN_PLAIN    = 8'h20;
    localparam logic [7:0]   MLEN_HALF     = 8'h40;
    localparam logic [7:0]   MLEN_THIRD    = 8'h60;
    localparam logic [7:0]   MLEN_QUARTER  = 8'h80;
    localparam logic [7:0]   MLEN_SIXTH    = 8'hC0;

    // ==========================================================
    // symbols per bit time at each rate
    localparam logic [2:0]   SPB_PLAIN     = 3'h1;
    localparam logic [2:0]   SPB_HALF      = 3'h2;
    localparam logic [2:0]   SPB_THIRD     = 3'h3;
    localparam logic [2:0]   SPB_QUARTER   = 3'h4;
    localparam logic [2:0]   SPB_SIXTH     = 3'h6;

    // default information block length in bits
    localparam int           BLOCK_LEN_DEF = 1784;

endpackage
`default_nettype wire

/* testbench/tcf_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// frame source upstream and symbol sink downstream
module tcf_far_model (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic stall_en,
    input  wire logic info_ready,
    output logic      info_bit,
    output logic      info_bit_perm,
    output logic      info_valid,
    input  wire logic sym_out_q,
    input  wire logic sym_valid_q,
    input  wire logic sym_is_marker_q,
    input  wire logic sym_unit_start_q,
    output logic      sym_ready
);
    logic [15:0] lfsr_q;
    logic [7:0]  cyc_q;
    logic        take_q[$];
    logic        perm_q[$];
    logic [2:0]  got_q[$];
    int          starts;

    // ==========================================================
    // source holds each bit until taken; sink stalls one cycle in four when stall_en is set
    initial begin
        lfsr_q = 16'hACE1;
        cyc_q = 8'h00;
        starts = 0;
        info_valid = 1'h0;
        info_bit = 1'h0;
        info_bit_perm = 1'h0;
        sym_ready = 1'h0;
        forever begin
            @(posedge clock);
            if (rstn && info_valid && info_ready) begin
                take_q.push_back(info_bit);
                perm_q.push_back(info_bit_perm);
                lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            end
            // symbol record is {unit start, marker flag, symbol}
            if (rstn && sym_valid_q && sym_ready) begin
                got_q.push_back({sym_unit_start_q, sym_is_marker_q, sym_out_q});
                if (sym_unit_start_q) starts++;
            end
            cyc_q = cyc_q + 8'h01;
            #1;
            info_valid = rstn;
            info_bit = lfsr_q[0];
            info_bit_perm = lfsr_q[7];
            sym_ready = !(stall_en && cyc_q[1:0] == 2'h3);
        end
    end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// self-checking bench for the codeblock sync framer
module testbench import tcf_pkg::*;;
    logic        clock, rstn, run_en, turbo_en, stall_en;
    logic [1:0]  rate_sel;
    logic [14:0] block_len;
    logic        info_bit, info_bit_perm, info_valid, info_ready;
    logic        sym_out_q, sym_valid_q, sym_is_marker_q, sym_unit_start_q, sym_ready;
    logic [2:0]  exp_q[$];
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;

    tcf_framer tcf_framer_inst (
        .clock            (clock),
        .rstn             (rstn),
        .run_en           (run_en),
        .turbo_en         (turbo_en),
        .rate_sel         (rate_sel),
        .block_len        (block_len),
        .info_bit         (info_bit),
        .info_bit_perm    (info_bit_perm),
        .info_valid       (info_valid),
        .info_ready       (info_ready),
        .sym_out_q        (sym_out_q),
        .sym_valid_q      (sym_valid_q),
        .sym_is_marker_q  (sym_is_marker_q),
        .sym_unit_start_q (sym_unit_start_q),
        .sym_ready        (sym_ready)
    );

    tcf_far_model tcf_far_model_inst (
        .clock            (clock),
        .rstn             (rstn),
        .stall_en         (stall_en),
        .info_ready       (info_ready),
        .info_bit         (info_bit),
        .info_bit_perm    (info_bit_perm),
        .info_valid       (info_valid),
        .sym_out_q        (sym_out_q),
        .sym_valid_q      (sym_valid_q),
        .sym_is_marker_q  (sym_is_marker_q),
        .sym_unit_start_q (sym_unit_start_q),
        .sym_ready        (sym_ready)
    );

    // ==========================================================
    // compare helpers and closing report
    task automatic chk_sym(input logic [2:0] e, input logic [2:0] g, input int idx);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t: symbol %0d exp %h got %h", $time, idx, e, g);
        end
    endtask

    task automatic chk_int(input int e, input int g, input int idx);
        checked++;
        if (g != e) begin
            failures++;
            $display("ERROR %0t: count %0d exp %0d got %0d", $time, idx, e, g);
        end
    endtask

    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // marker pattern, marker length and symbols per bit time of a mode
    task automatic mode_of(input logic tu, input logic [1:0] r, output logic [191:0] mk,
                           output int ml, output int sp);
        mk = MARK_PLAIN;
        ml = MLEN_PLAIN;
        sp = SPB_PLAIN;
        if (tu) begin
            case (r)
                2'h0: begin mk = MARK_HALF; ml = MLEN_HALF; sp = SPB_HALF; end
                2'h1: begin mk = MARK_THIRD; ml = MLEN_THIRD; sp = SPB_THIRD; end
                2'h2: begin mk = MARK_QUARTER; ml = MLEN_QUARTER; sp = SPB_QUARTER; end
                default: begin mk = MARK_SIXTH; ml = MLEN_SIXTH; sp = SPB_SIXTH; end
            endcase
        end
    endtask

    // reference encoders: s = {p3b, p1b, p3a, p2a, p1a, systematic}
    task automatic build_unit(input logic tu, input logic [1:0] r, input int k, inout int pos);
        logic [191:0] mk;
        logic [3:0]   sa, sb;
        logic [5:0]   s;
        logic         aa, ab;
        int           ml, sp;
        mode_of(tu, r, mk, ml, sp);
        for (int i = 0; i < ml; i++) exp_q.push_back({i == 0, 1'h1, mk[191 - i]});
        sa = 4'h0;
        sb = 4'h0;
        for (int t = 0; t < (tu ? k + 4 : k); t++) begin
            s[0] = (t < k) ? tcf_far_model_inst.take_q[pos + t] : sa[2] ^ sa[3];
            s[4] = (t < k) ? tcf_far_model_inst.perm_q[pos + t] : sb[2] ^ sb[3];
            aa = s[0] ^ sa[2] ^ sa[3];
            ab = s[4] ^ sb[2] ^ sb[3];
            s[1] = aa ^ sa[0] ^ sa[2] ^ sa[3];
            s[2] = aa ^ sa[1] ^ sa[3];
            s[3] = aa ^ (^sa);
            s[5] = ab ^ (^sb);
            s[4] = ab ^ sb[0] ^ sb[2] ^ sb[3];
            exp_q.push_back({2'h0, s[0]});
            if (tu) begin
                case (r)
                    2'h0: exp_q.push_back({2'h0, t[0] ? s[4] : s[1]});
                    2'h1: begin exp_q.push_back({2'h0, s[1]}); exp_q.push_back({2'h0, s[4]}); end
                    2'h2: for (int j = 2; j < 5; j++) exp_q.push_back({2'h0, s[j]});
                    default: for (int j = 1; j < 6; j++) exp_q.push_back({2'h0, s[j]});
                endcase
            end
            sa = {sa[2:0], aa};
            sb = {sb[2:0], ab};
        end
        pos += k;
    endtask

    // ==========================================================
    // reset with output checks, then two back-to-back units
    task automatic do_reset;
        #1;
        rstn = 1'h0;
        run_en = 1'h0;
        tcf_far_model_inst.take_q.delete();
        tcf_far_model_inst.perm_q.delete();
        tcf_far_model_inst.got_q.delete();
        tcf_far_model_inst.starts = 0;
        exp_q.delete();
        repeat (4) @(posedge clock);
        chk_sym(3'h0, {sym_unit_start_q, sym_is_marker_q, sym_out_q}, -1);
        chk_sym(3'h0, {sym_valid_q, info_ready, 1'h0}, -2);
        #1;
        rstn = 1'h1;
        @(posedge clock);
        #1;
    endtask

    task automatic run_pair(input logic tu, input logic [1:0] ra, input int ka,
                            input logic [1:0] rb, input int kb, input logic st);
        logic [191:0] mk;
        int           n, pos, tot, ml, sp;
        do_reset;
        turbo_en = tu;
        rate_sel = ra;
        block_len = ka[14:0];
        stall_en = st;
        run_en = 1'h1;
        for (n = 0; n < 600 && tcf_far_model_inst.starts < 1; n++) @(posedge clock);
        #1;
        rate_sel = rb;
        block_len = kb[14:0];
        for (n = 0; n < 3000 && tcf_far_model_inst.starts < 2; n++) @(posedge clock);
        #1;
        run_en = 1'h0;
        mode_of(tu, ra, mk, ml, sp);
        tot = ml + sp * (tu ? ka + 4 : ka);
        mode_of(tu, rb, mk, ml, sp);
        tot += ml + sp * (tu ? kb + 4 : kb);
        for (n = 0; n < 4000 && tcf_far_model_inst.got_q.size() < tot; n++) @(posedge clock);
        repeat (20) @(posedge clock);
        chk_int(tot, tcf_far_model_inst.got_q.size(), 0);
        chk_int(ka + kb, tcf_far_model_inst.take_q.size(), 1);
        if (tcf_far_model_inst.take_q.size() == ka + kb) begin
            pos = 0;
            build_unit(tu, ra, ka, pos);
            build_unit(tu, rb, kb, pos);
            foreach (exp_q[i]) begin
                if (i < tcf_far_model_inst.got_q.size()) begin
                    chk_sym(exp_q[i], tcf_far_model_inst.got_q[i], i);
                end
            end
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_plain;
        run_pair(1'h0, 2'h0, 16, 2'h3, 1, 1'h0);
    endtask

    task automatic t_rates;
        for (int r = 0; r < 4; r++) run_pair(1'h1, r[1:0], 12, r[1:0], 12, r[0]);
    endtask

    task automatic t_switch;
        run_pair(1'h1, 2'h1, 12, 2'h3, 20, 1'h1);
        run_pair(1'h1, 2'h0, 2, 2'h2, 6, 1'h0);
    endtask

    // ==========================================================
    // clock, hang ceiling and main sequence
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            $display("ERROR %0t: cycle ceiling reached", $time);
            wrap_up;
        end
    end

    initial begin
        rstn = 1'h0;
        run_en = 1'h0;
        turbo_en = 1'h0;
        rate_sel = 2'h0;
        block_len = 15'h0010;
        stall_en = 1'h0;
        t_plain;
        t_rates;
        t_switch;
        wrap_up;
    end
endmodule
`default_nettype wire
